// ===== core/pbd_pkg.sv
// Shared constants, types and state codes for the packet buffer DMA pair.
// Assumes both ends import this package; the link interface does not use it.
package pbd_pkg;
  localparam int PTR_W = 16;
  typedef logic [PTR_W-1:0] pbd_ptr_t;
  // Local buffer size in bytes; must be a power of two.
  localparam int MEM_SIZE = 4096;
  // Transmit area size; the receive area starts right above it.
  localparam int TX_SIZE = 256;
  // Host FIFO depth in bytes; must be a power of two.
  localparam int FIFO_DEPTH = 16;
  // Header geometry: four bytes, offsets 0 to 3.
  localparam pbd_ptr_t HDR_LEN = 16'h0004;
  localparam logic [1:0] HDR_LAST = 2'h3;
  // Buffer selection code that picks the local buffer.
  localparam logic [3:0] BUF_CODE_LOCAL = 4'h8;
  localparam pbd_ptr_t PTR_RESET = 16'h0000;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_NULL = 4'h2,
    RX_RECV = 4'h4,
    RX_HDR = 4'h8
  } pbd_rx_st_t;
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_RXEN = 7'h02,
    H_EMPTY = 7'h04,
    H_LOAD = 7'h08,
    H_WIN = 7'h10,
    H_READ = 7'h20,
    H_DONE = 7'h40
  } pbd_host_st_t;
endpackage

// ===== core/pbd_if.sv
// Link between the packet buffer device end and its host end.
// Assumes the testbench instantiates it and joins both ends to it.
`timescale 1ns/10ps
interface pbd_if;
  logic bus_width_select;
  logic [3:0] buf_code;
  logic fifo_dir_rd;
  logic fifo_rd_bit;
  logic dma_ptr_load;
  logic rx_ptr_load;
  logic [15:0] ptr_data;
  logic rx_enable;
  logic data_rd;
  logic data_wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic fifo_empty;
  logic buf_window;
  logic read_fault;
  modport dev(
    input bus_width_select, buf_code, fifo_dir_rd, fifo_rd_bit, dma_ptr_load,
    input rx_ptr_load, ptr_data, rx_enable, data_rd, data_wr, wdata,
    output rdata, rvalid, fifo_empty, buf_window, read_fault
  );
  modport host(
    output bus_width_select, buf_code, fifo_dir_rd, fifo_rd_bit, dma_ptr_load,
    output rx_ptr_load, ptr_data, rx_enable, data_rd, data_wr, wdata,
    input rdata, rvalid, fifo_empty, buf_window, read_fault
  );
endinterface

// ===== core/pbd_fifo.sv
// Byte FIFO that takes and gives up to two bytes a cycle, with flush.
// Assumes the caller never pushes past full nor pops past empty.
`timescale 1ns/10ps
module pbd_fifo #(
  parameter int DEPTH = pbd_pkg::FIFO_DEPTH
) (
  // Clock, reset and clock enable.
  input logic clk,
  input logic reset,
  input logic ce,
  // Control.
  input logic flush,
  input logic [1:0] push_n,
  input logic [1:0] pop_n,
  // Data.
  input logic [7:0] in0,
  input logic [7:0] in1,
  output logic [7:0] out0,
  output logic [7:0] out1,
  output logic [$clog2(DEPTH):0] count
);
  import pbd_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [7:0] buf_q [DEPTH];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;

  // Pointers advance by the byte counts; a flush empties at once.
  always_comb begin
    rd_d = rd_q + AW'(pop_n);
    wr_d = wr_q + AW'(push_n);
    cnt_d = cnt_q + (AW+1)'(push_n) - (AW+1)'(pop_n);
    if (flush) begin
      rd_d = '0;
      wr_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only counted bytes are ever read.
  always_ff @(posedge clk) begin
    if (ce && !flush) begin
      if (push_n != 2'h0) buf_q[wr_q] <= in0;
      if (push_n == 2'h2) buf_q[wr_q + AW'(1)] <= in1;
    end
  end

  assign out0 = buf_q[rd_q];
  assign out1 = buf_q[rd_q + AW'(1)];
  assign count = cnt_q;
endmodule

// ===== core/pbd_dev_end.sv
// Device end: local packet buffer, receive header writer and host DMA FIFO.
// Assumes the host end keeps the loading and read ordering it is given.
//
// What this block does
// - Enabling receiver writes four-zero null header.
// - Packet end overwrites null header with header.
// - Header next pointer equals receive pointer.
// - Receiver stops only after writing null header.
// - Overflow writes partial null, at least one zero.
// - Null header ending at buffer top flags overflow.
// - Re-enable without reload adds second null header.
// - Host loads receive pointer before each enable.
// - Host stops walking at zero first header byte.
// - Transmit area at least 256 bytes.
// - FIFO may hold stale bytes after null.
// - Pointer load flushes FIFO; host reloads next pointer.
// - Read pointer runs from transmit into receive area.
// - Write pointer wraps inside its area automatically.
// - Host selects local buffer code before access.
// - Host waits FIFO empty in write direction first.
// - Host sets read direction after pointer load.
// - Window flag marks read data; host waits for it.
// - Pointer change or bad setup corrupts reads.
// - Host drives bus width select for 8/16 bits.
`timescale 1ns/10ps
module pbd_dev_end #(
  parameter int MEM_SIZE = pbd_pkg::MEM_SIZE,
  parameter int TX_SIZE = pbd_pkg::TX_SIZE,
  parameter int FIFO_DEPTH = pbd_pkg::FIFO_DEPTH
) (
  // Clock, reset and clock enable.
  input logic clk,
  input logic reset,
  input logic ce,
  // Link to the host end.
  pbd_if.dev bus,
  // Received byte stream from the receive engine.
  input logic rx_valid,
  input logic [7:0] rx_byte,
  input logic rx_last,
  input logic [7:0] rx_status,
  // Receive state.
  output logic rx_ready,
  output logic rx_active,
  output logic rx_overflow
);
  import pbd_pkg::*;
  localparam int MW = $clog2(MEM_SIZE);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam pbd_ptr_t MEM_TOP = pbd_ptr_t'(MEM_SIZE - 1);
  localparam pbd_ptr_t TX_TOP = pbd_ptr_t'(TX_SIZE - 1);
  localparam pbd_ptr_t RX_BASE = pbd_ptr_t'(TX_SIZE);
  localparam logic [CW-1:0] F_FULL = CW'(FIFO_DEPTH);

  logic [7:0] mem_q [MEM_SIZE];

  //////////////////////////////////////////////////////////////////////////////
  // Receive header writer.
  pbd_rx_st_t rx_st_q, rx_st_d;
  logic [1:0] cnt_q, cnt_d;
  pbd_ptr_t rx_ptr_q, rx_ptr_d, hdr_q, hdr_d, wptr_q, wptr_d, rx_wa;
  logic stop_q, stop_d, ovf_q, ovf_d, en_prev_q;
  logic [7:0] status_q, status_d, rx_wd;
  logic rx_ready_q, rx_active_q, rx_we;

  // Walks null header, packet data and header update, one byte a cycle.
  always_comb begin
    rx_st_d = rx_st_q;
    cnt_d = cnt_q;
    rx_ptr_d = rx_ptr_q;
    hdr_d = hdr_q;
    wptr_d = wptr_q;
    ovf_d = ovf_q;
    status_d = status_q;
    stop_d = stop_q | !bus.rx_enable;
    rx_we = 1'b0;
    rx_wa = hdr_q + 16'(cnt_q);
    rx_wd = 8'h00;
    unique case (rx_st_q)
      RX_IDLE: begin
        if (bus.rx_ptr_load) rx_ptr_d = bus.ptr_data;
        if (bus.rx_enable && !en_prev_q) begin // Starts at the pointer as it stands.
          hdr_d = rx_ptr_q;
          cnt_d = 2'h0;
          stop_d = 1'b0;
          ovf_d = 1'b0;
          rx_st_d = RX_NULL;
        end
      end
      RX_NULL: begin
        rx_we = 1'b1;
        cnt_d = cnt_q + 2'h1;
        if (rx_wa == MEM_TOP) begin
          ovf_d = 1'b1;
          stop_d = 1'b1;
        end
        if (rx_wa == MEM_TOP || cnt_q == HDR_LAST) begin
          if (stop_d) begin
            rx_ptr_d = rx_wa + 16'h0001;
            rx_st_d = RX_IDLE;
          end else begin
            wptr_d = hdr_q + HDR_LEN;
            rx_st_d = RX_RECV;
          end
        end
      end
      RX_RECV: begin
        if (stop_q && wptr_q == hdr_q + HDR_LEN) begin
          // Disabled between packets: the null header already stands.
          rx_ptr_d = wptr_q;
          rx_st_d = RX_IDLE;
        end else if (rx_valid && rx_ready_q) begin
          if (wptr_q == MEM_TOP) begin
            ovf_d = 1'b1; // Top byte is kept for the partial null header.
            stop_d = 1'b1;
            rx_ptr_d = wptr_q;
            status_d = rx_status;
            cnt_d = 2'h0;
            rx_st_d = RX_HDR;
          end else begin
            rx_we = 1'b1;
            rx_wa = wptr_q;
            rx_wd = rx_byte;
            wptr_d = wptr_q + 16'h0001;
            if (rx_last) begin
              rx_ptr_d = wptr_q + 16'h0001;
              status_d = rx_status;
              cnt_d = 2'h0;
              rx_st_d = RX_HDR;
            end
          end
        end
      end
      RX_HDR: begin
        // Next pointer high, low, status, overflow flag.
        rx_we = 1'b1;
        unique case (cnt_q)
          2'h0: rx_wd = rx_ptr_q[15:8];
          2'h1: rx_wd = rx_ptr_q[7:0];
          2'h2: rx_wd = status_q;
          2'h3: rx_wd = {7'h00, ovf_q};
        endcase
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == HDR_LAST) begin
          hdr_d = rx_ptr_q;
          rx_st_d = RX_NULL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_q <= RX_IDLE;
      cnt_q <= 2'h0;
      rx_ptr_q <= PTR_RESET;
      hdr_q <= PTR_RESET;
      wptr_q <= PTR_RESET;
      stop_q <= 1'b1;
      ovf_q <= 1'b0;
      status_q <= 8'h00;
      en_prev_q <= 1'b0;
      rx_ready_q <= 1'b0;
      rx_active_q <= 1'b0;
    end else if (ce) begin
      rx_st_q <= rx_st_d;
      cnt_q <= cnt_d;
      rx_ptr_q <= rx_ptr_d;
      hdr_q <= hdr_d;
      wptr_q <= wptr_d;
      stop_q <= stop_d;
      ovf_q <= ovf_d;
      status_q <= status_d;
      en_prev_q <= bus.rx_enable;
      // A stop mid-packet still takes the rest of the packet.
      rx_ready_q <= (rx_st_d == RX_RECV) && !(stop_d && wptr_d == hdr_d + HDR_LEN);
      rx_active_q <= (rx_st_d != RX_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host DMA pointer and FIFO.
  pbd_ptr_t dma_ptr_q, dma_ptr_d, next_rd, next_wr;
  logic [1:0] push_n, pop_n, bw_n;
  logic [7:0] in0, in1, f_out0, f_out1;
  logic [CW-1:0] fcnt;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, empty_q, window_q, fault_q, fault_d;
  logic dma_we, dma_on, dir_prev_q, f_flush;

  pbd_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .reset(reset), .ce(ce), .flush(f_flush), .push_n(push_n), .pop_n(pop_n),
    .in0(in0), .in1(in1), .out0(f_out0), .out1(f_out1), .count(fcnt)
  );

  // Fills the FIFO in read direction and drains it in write direction.
  always_comb begin
    next_rd = (dma_ptr_q == MEM_TOP) ? RX_BASE : dma_ptr_q + 16'h0001;
    next_wr = (dma_ptr_q == TX_TOP) ? PTR_RESET : next_rd;
    dma_on = (bus.buf_code == BUF_CODE_LOCAL);
    bw_n = bus.bus_width_select ? 2'h2 : 2'h1;
    f_flush = bus.dma_ptr_load || (dir_prev_q && !bus.fifo_dir_rd); // Read-ahead never stored.
    dma_ptr_d = dma_ptr_q;
    push_n = 2'h0;
    pop_n = 2'h0;
    in0 = bus.wdata[7:0];
    in1 = bus.wdata[15:8];
    dma_we = 1'b0;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (bus.dma_ptr_load) begin
      dma_ptr_d = bus.ptr_data;
    end else if (dma_on && bus.fifo_dir_rd) begin // Stale read-ahead stays queued.
      if (bus.data_rd && fcnt >= CW'(bw_n)) begin
        pop_n = bw_n;
        rdata_d = bus.bus_width_select ? {f_out1, f_out0} : {8'h00, f_out0};
        rvalid_d = 1'b1;
      end
      if (fcnt < F_FULL) begin
        push_n = 2'h1;
        in0 = mem_q[dma_ptr_q[MW-1:0]];
        dma_ptr_d = next_rd;
      end
    end else if (dma_on) begin
      if (bus.data_wr && fcnt + CW'(bw_n) <= F_FULL) push_n = bw_n;
      // Receive null, data and header writes own the buffer port first.
      if (fcnt != '0 && !rx_we && !f_flush) begin
        dma_we = 1'b1;
        pop_n = 2'h1;
        dma_ptr_d = next_wr;
      end
    end
    // Pointer moved or bad setup while reading; set wins over clear.
    fault_d = fault_q;
    if (bus.dma_ptr_load && !bus.fifo_dir_rd) fault_d = 1'b0;
    if (bus.fifo_dir_rd && (bus.dma_ptr_load || (bus.bus_width_select &&
        (!dma_on || bus.fifo_rd_bit)))) fault_d = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dma_ptr_q <= PTR_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      empty_q <= 1'b1;
      window_q <= 1'b0;
      fault_q <= 1'b0;
      dir_prev_q <= 1'b0;
    end else if (ce) begin
      dma_ptr_q <= dma_ptr_d;
      dir_prev_q <= bus.fifo_dir_rd;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      empty_q <= (fcnt == '0);
      window_q <= bus.fifo_dir_rd && (fcnt != '0);
      fault_q <= fault_d;
    end
  end

  // Single buffer write port; receive writes take precedence.
  always_ff @(posedge clk) begin
    if (ce && rx_we) mem_q[rx_wa[MW-1:0]] <= rx_wd;
    else if (ce && dma_we) mem_q[dma_ptr_q[MW-1:0]] <= f_out0;
  end

  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign bus.fifo_empty = empty_q;
  assign bus.buf_window = window_q;
  assign bus.read_fault = fault_q;
  assign rx_ready = rx_ready_q;
  assign rx_active = rx_active_q;
  assign rx_overflow = ovf_q;
endmodule

// ===== core/pbd_host_end.sv
// Host end: starts the receiver and walks received packet headers.
// Assumes the device end sits on the other side of the link interface.
`timescale 1ns/10ps
module pbd_host_end #(
  parameter bit BUS16 = 1'b0,
  parameter int TX_SIZE = pbd_pkg::TX_SIZE
) (
  // Clock, reset and clock enable.
  input logic clk,
  input logic reset,
  input logic ce,
  // Link to the device end.
  pbd_if.host bus,
  // User commands.
  input logic start_rx,
  input pbd_pkg::pbd_ptr_t rx_base,
  input logic stop_rx,
  input logic walk,
  // User results.
  output logic busy,
  output logic hdr_valid,
  output logic [31:0] hdr_data,
  output logic chain_end
);
  import pbd_pkg::*;
  localparam pbd_ptr_t RX_BASE = pbd_ptr_t'(TX_SIZE);

  pbd_host_st_t st_q, st_d;
  logic dir_q, dir_d, pload_q, pload_d, rload_q, rload_d, en_q, en_d;
  logic rd_q, rd_d, w_q, w_d, hv_q, hv_d, end_q, end_d;
  logic [3:0] code_q, code_d;
  pbd_ptr_t pdata_q, pdata_d, next_q, next_d;
  logic [31:0] hdr_q, hdr_d;
  logic [2:0] nb_q, nb_d;

  // Command sequencer for receiver start and header walk.
  always_comb begin
    st_d = st_q;
    dir_d = dir_q;
    pload_d = 1'b0;
    rload_d = 1'b0;
    en_d = en_q;
    rd_d = 1'b0;
    w_d = w_q;
    hv_d = 1'b0;
    end_d = end_q;
    code_d = code_q;
    pdata_d = pdata_q;
    next_d = next_q;
    hdr_d = hdr_q;
    nb_d = nb_q;
    unique case (st_q)
      H_IDLE: begin
        if (stop_rx) en_d = 1'b0;
        if (start_rx) begin
          // Pointer first, enable a cycle later.
          pdata_d = (rx_base < RX_BASE) ? RX_BASE : rx_base;
          next_d = pdata_d;
          rload_d = 1'b1;
          en_d = 1'b0;
          st_d = H_RXEN;
        end else if (walk) begin
          code_d = BUF_CODE_LOCAL;
          dir_d = 1'b0;
          st_d = H_EMPTY;
        end
      end
      H_RXEN: begin
        en_d = 1'b1;
        st_d = H_IDLE;
      end
      H_EMPTY: begin
        if (bus.fifo_empty && !dir_q) begin
          pdata_d = next_q;
          pload_d = 1'b1;
          st_d = H_LOAD;
        end
      end
      H_LOAD: begin
        dir_d = 1'b1;
        nb_d = 3'h0;
        hdr_d = 32'h00000000;
        st_d = H_WIN;
      end
      H_WIN: begin
        if (bus.buf_window) begin
          rd_d = 1'b1;
          w_d = 1'b0;
          st_d = H_READ;
        end
      end
      H_READ: begin
        w_d = 1'b1;
        if (w_q) begin
          w_d = 1'b0;
          if (bus.rvalid) begin
            hdr_d = BUS16 ? {hdr_q[15:0], bus.rdata[7:0], bus.rdata[15:8]}
                          : {hdr_q[23:0], bus.rdata[7:0]};
            nb_d = nb_q + (BUS16 ? 3'h2 : 3'h1);
          end
          if (nb_d == 3'h4) st_d = H_DONE;
          else rd_d = 1'b1;
        end
      end
      H_DONE: begin
        hv_d = 1'b1;
        end_d = (hdr_q[31:24] == 8'h00);
        if (!end_d) next_d = hdr_q[31:16];
        st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE;
      dir_q <= 1'b0;
      pload_q <= 1'b0;
      rload_q <= 1'b0;
      en_q <= 1'b0;
      rd_q <= 1'b0;
      w_q <= 1'b0;
      hv_q <= 1'b0;
      end_q <= 1'b0;
      code_q <= BUF_CODE_LOCAL;
      pdata_q <= PTR_RESET;
      next_q <= RX_BASE;
      hdr_q <= 32'h00000000;
      nb_q <= 3'h0;
    end else if (ce) begin
      st_q <= st_d;
      dir_q <= dir_d;
      pload_q <= pload_d;
      rload_q <= rload_d;
      en_q <= en_d;
      rd_q <= rd_d;
      w_q <= w_d;
      hv_q <= hv_d;
      end_q <= end_d;
      code_q <= code_d;
      pdata_q <= pdata_d;
      next_q <= next_d;
      hdr_q <= hdr_d;
      nb_q <= nb_d;
    end
  end

  // Width select is fixed by the host's bus build.
  assign bus.bus_width_select = BUS16;
  assign bus.buf_code = code_q;
  assign bus.fifo_dir_rd = dir_q;
  assign bus.fifo_rd_bit = 1'b0;
  assign bus.dma_ptr_load = pload_q;
  assign bus.rx_ptr_load = rload_q;
  assign bus.ptr_data = pdata_q;
  assign bus.rx_enable = en_q;
  assign bus.data_rd = rd_q;
  assign bus.data_wr = 1'b0;
  assign bus.wdata = 16'h0000;
  assign busy = (st_q != H_IDLE);
  assign hdr_valid = hv_q;
  assign hdr_data = hdr_q;
  assign chain_end = end_q;
endmodule

// ===== testbench/pbd_link_chk.sv
// Checker on the link between the packet buffer device end and host end.
// Assumes it is wired beside the link interface with the clock enable held high.
`timescale 1ns/10ps
module pbd_link_chk
  import pbd_pkg::*;
#(
  parameter bit BUS16 = 1'b0
) (
  // Clock and reset.
  input logic clk,
  input logic reset,
  // Host to device.
  input logic bus_width_select,
  input logic [3:0] buf_code,
  input logic fifo_dir_rd,
  input logic dma_ptr_load,
  input logic rx_ptr_load,
  input logic rx_enable,
  input logic data_rd,
  // Device to host.
  input logic [15:0] rdata,
  input logic rvalid,
  input logic fifo_empty,
  input logic buf_window,
  input logic read_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Read answers come one cycle after a taken read and last a single cycle.
  property p_rvalid_pulse;
    rvalid |=> !rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("rvalid held longer than one cycle");
  property p_rvalid_cause;
    rvalid |-> $past(data_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("rvalid without a read one cycle before");
  property p_rdata_hold;
    $changed(rdata) |-> rvalid;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("rdata changed without rvalid");
  // The host reads only in read direction once the window flag is up.
  property p_read_window;
    data_rd |-> buf_window && fifo_dir_rd;
  endproperty
  a_read_window: assert property (p_read_window)
    else $error("read issued before the window flag");

  ////////////////////////////////////////////////////////////////////////////
  // Pointer loads happen in write direction, local code, FIFO empty.
  property p_load_setup;
    dma_ptr_load |-> !fifo_dir_rd && fifo_empty && buf_code == BUF_CODE_LOCAL;
  endproperty
  a_load_setup: assert property (p_load_setup)
    else $error("pointer load without the required setup");
  property p_read_after_load;
    dma_ptr_load |=> fifo_dir_rd;
  endproperty
  a_read_after_load: assert property (p_read_after_load)
    else $error("read direction not set after pointer load");
  property p_window_after_load;
    dma_ptr_load |-> ##[2:40] buf_window;
  endproperty
  a_window_after_load: assert property (p_window_after_load)
    else $error("FIFO not refilled after pointer load");
  property p_load_clears_fault;
    dma_ptr_load |=> !read_fault;
  endproperty
  a_load_clears_fault: assert property (p_load_clears_fault)
    else $error("read fault not cleared by a clean load");
  property p_fault_free;
    $rose(read_fault) |-> $past(dma_ptr_load && fifo_dir_rd);
  endproperty
  a_fault_free: assert property (p_fault_free)
    else $error("read fault raised without a cause");

  ////////////////////////////////////////////////////////////////////////////
  // Receiver enable follows a receive pointer load; bus width is fixed.
  property p_rx_load_first;
    $rose(rx_enable) |-> $past(rx_ptr_load);
  endproperty
  a_rx_load_first: assert property (p_rx_load_first)
    else $error("receiver enabled without pointer load");
  property p_width_fixed;
    bus_width_select == BUS16;
  endproperty
  a_width_fixed: assert property (p_width_fixed)
    else $error("bus width select differs from the host setting");
endmodule

// ===== testbench/packet_buffer_null_header_dma_tb.sv
// Testbench for the packet buffer DMA pair joined through the link interface.
// Assumes a 512 byte buffer so that overflow is reached in a short run.
`timescale 1ns/10ps
module packet_buffer_null_header_dma_tb;
  import pbd_pkg::*;
  localparam int MSZ = 512;
  localparam int TSZ = 256;
  localparam int LIMIT = 20000;
  logic clk;
  logic reset;
  logic rx_valid, rx_last, rx_ready, rx_active, rx_overflow;
  logic [7:0] rx_byte;
  logic [7:0] rx_status;
  logic start_rx, stop_rx, walk, busy, hdr_valid, chain_end;
  pbd_ptr_t rx_base;
  logic [31:0] hdr_data;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed, h;
  pbd_ptr_t p, q;
  logic [7:0] st;
  logic e, tk;

  pbd_if u_pbd_if();
  pbd_dev_end #(.MEM_SIZE(MSZ), .TX_SIZE(TSZ), .FIFO_DEPTH(FIFO_DEPTH)) u_pbd_dev_end (
    .clk(clk), .reset(reset), .ce(1'b1), .bus(u_pbd_if.dev), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready),
    .rx_active(rx_active), .rx_overflow(rx_overflow));
  pbd_host_end #(.BUS16(1'b0), .TX_SIZE(TSZ)) u_pbd_host_end (
    .clk(clk), .reset(reset), .ce(1'b1), .bus(u_pbd_if.host), .start_rx(start_rx),
    .rx_base(rx_base), .stop_rx(stop_rx), .walk(walk), .busy(busy),
    .hdr_valid(hdr_valid), .hdr_data(hdr_data), .chain_end(chain_end));
  pbd_link_chk #(.BUS16(1'b0)) u_pbd_link_chk (
    .clk(clk), .reset(reset), .bus_width_select(u_pbd_if.bus_width_select),
    .buf_code(u_pbd_if.buf_code), .fifo_dir_rd(u_pbd_if.fifo_dir_rd),
    .dma_ptr_load(u_pbd_if.dma_ptr_load), .rx_ptr_load(u_pbd_if.rx_ptr_load),
    .rx_enable(u_pbd_if.rx_enable), .data_rd(u_pbd_if.data_rd), .rdata(u_pbd_if.rdata),
    .rvalid(u_pbd_if.rvalid), .fifo_empty(u_pbd_if.fifo_empty),
    .buf_window(u_pbd_if.buf_window), .read_fault(u_pbd_if.read_fault));

  ////////////////////////////////////////////////////////////////////////////
  // Xorshift source and expected header layout.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] hdr_exp(input pbd_ptr_t nx, input logic [7:0] s);
    return {nx, s, 8'h00};
  endfunction

  // Compare, pulse, bounded wait, header walk and byte send helpers.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_lvl(input string nm, ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 500) begin
      @(negedge clk);
      i++;
    end
    chk(nm, {31'h0, v}, {31'h0, s});
  endtask
  task automatic do_walk();
    pulse(walk);
    wait_lvl("hdr_valid", hdr_valid, 1'b1);
    h = hdr_data;
    e = chain_end;
    wait_lvl("busy", busy, 1'b0);
  endtask
  task automatic send(input logic [7:0] b, input logic last, output logic took);
    int i;
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte = b;
    rx_last = last;
    i = 0;
    while (rx_ready !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    took = (rx_ready === 1'b1);
    @(negedge clk);
    rx_valid = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end

  // Main sequence: null header, random packets with stop, restart and overflow.
  initial begin
    seed = 32'h000143ad;
    reset = 1'b1;
    {rx_valid, rx_last, start_rx, stop_rx, walk} = 5'h00;
    rx_byte = 8'h00;
    rx_status = 8'h00;
    rx_base = 16'h0000;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    p = pbd_ptr_t'(TSZ);
    rx_base = p;
    pulse(start_rx);
    wait_lvl("busy", busy, 1'b0);
    wait_lvl("rx_ready", rx_ready, 1'b1);
    do_walk();
    chk("null_hdr", 32'h0, h);
    chk("chain_end", 32'h1, {31'h0, e});
    $display("test null header done");
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      n = 1 + int'(seed[3:0]);
      st = seed[15:8];
      rx_status = st;
      for (int j = 0; j < n; j++) begin
        seed = xs(seed);
        send(seed[7:0], j == n - 1, tk);
        chk("taken", 32'h1, {31'h0, tk});
        if (k == 2 && j == 0) pulse(stop_rx);
      end
      q = p + HDR_LEN + pbd_ptr_t'(n);
      repeat (2) @(negedge clk);
      if (k == 2) wait_lvl("rx_active", rx_active, 1'b0);
      else wait_lvl("rx_ready", rx_ready, 1'b1);
      do_walk();
      chk("hdr", hdr_exp(q, st), h);
      chk("chain_end", 32'h0, {31'h0, e});
      do_walk();
      chk("null_hdr", 32'h0, h);
      p = q;
      $display("test packet %0d done", k);
    end
    // Restart after reloading the receive pointer, then run into the top.
    rx_base = p;
    pulse(start_rx);
    wait_lvl("busy", busy, 1'b0);
    wait_lvl("rx_ready", rx_ready, 1'b1);
    do_walk();
    chk("restart_null", 32'h0, h);
    rx_status = 8'h5a;
    n = 0;
    tk = 1'b1;
    while (tk && n < 400) begin
      seed = xs(seed);
      send(seed[7:0], 1'b0, tk);
      n++;
    end
    chk("rx_overflow", 32'h1, {31'h0, rx_overflow});
    wait_lvl("rx_active", rx_active, 1'b0);
    do_walk();
    chk("ovf_next", {16'h0000, pbd_ptr_t'(MSZ - 1)}, {16'h0000, h[31:16]});
    chk("ovf_flag", 32'h1, {31'h0, h[0]});
    do_walk();
    chk("ovf_end", 32'h1, {31'h0, e});
    $display("test overflow done");
    end_of_test();
  end
endmodule
